// ===== redriver_cfg_pkg.sv
// Constants shared by the redriver settings register bank and its channel slices.
// Assumes nothing of its surroundings; compiled before every other file.
package redriver_cfg_pkg;

    // Slave addresses of the two channel banks
    localparam logic [6:0] BANK0_SLAVE_ADDR = 7'h18;
    localparam logic [6:0] BANK1_SLAVE_ADDR = 7'h19;

    // Register offsets within a bank
    localparam logic [7:0] OFF_SEL_OVERRIDE = 8'h0E;
    localparam logic [7:0] OFF_SEL_VALUE    = 8'h0F;
    localparam logic [7:0] OFF_BCAST_GS     = 8'h82;
    localparam logic [7:0] OFF_CH0_GS       = 8'h02;
    localparam logic [7:0] OFF_CH1_GS       = 8'h22;

    // Field positions
    localparam int unsigned SEL_BIT   = 2;
    localparam int unsigned GAIN_BIT  = 2;
    localparam int unsigned SWING_LSB = 0;
    localparam int unsigned SWING_W   = 2;

    // Values after reset
    localparam logic               SEL_RESET   = 1'b0;
    localparam logic               OVR_RESET   = 1'b0;
    localparam logic               GAIN_RESET  = 1'b0;
    localparam logic [SWING_W-1:0] SWING_RESET = 2'h3;

    // Output swing codes
    localparam logic [SWING_W-1:0] SWING_M6P0_DB = 2'h0;
    localparam logic [SWING_W-1:0] SWING_M3P5_DB = 2'h1;
    localparam logic [SWING_W-1:0] SWING_M1P6_DB = 2'h2;
    localparam logic [SWING_W-1:0] SWING_0_DB    = 2'h3;

    // Geometry
    localparam int unsigned NUM_BANKS     = 2;
    localparam int unsigned CH_PER_BANK   = 2;
    localparam int unsigned NUM_CHANNELS  = 4;

    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_ADDR  = 4'h1,
        S_AACK  = 4'h3,
        S_REG   = 4'h2,
        S_RACK  = 4'h6,
        S_WDATA = 4'h7,
        S_WACK  = 4'h5,
        S_RD    = 4'h4,
        S_RDACK = 4'hC
    } link_state_t;

endpackage

// ===== reg_write_if.sv
// Register write strobe and read-back path between the serial engine and the settings.
// Assumes a single clock shared by every party on it.
`timescale 1ns/1ps
interface reg_write_if;
    logic       wr_en;
    logic       bank;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport engine (output wr_en, output bank, output addr, output wdata, input rdata);
    modport sink   (input wr_en, input bank, input addr, input wdata);
endinterface

// ===== chan_setting.sv
// One channel's DC gain and output swing setting.
// Assumes write strobes from the serial engine on the same clock.
`timescale 1ns/1ps
module chan_setting
    import redriver_cfg_pkg::*;
#(
    parameter logic BANK_IDX = 1'b0,
    parameter logic CH_IDX   = 1'b0
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset,
    // Write bus
    reg_write_if.sink               bus,
    // Settings
    output logic                    gain_q,
    output logic [SWING_W-1:0]      swing_q
);

    logic own_offset;
    logic hit;

    assign own_offset = (bus.addr == (CH_IDX ? OFF_CH1_GS : OFF_CH0_GS));
    assign hit = bus.wr_en && (bus.bank == BANK_IDX) && (own_offset || bus.addr == OFF_BCAST_GS);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gain_q <= GAIN_RESET;
        end else if (hit) begin
            gain_q <= bus.wdata[GAIN_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            swing_q <= SWING_RESET;
        end else if (hit) begin
            swing_q <= bus.wdata[SWING_LSB +: SWING_W];
        end
    end

endmodule

// ===== port_select_and_swing_regs.sv
// Register bank of a four-channel redriver reached over its two-wire serial port.
// Assumes SCL and SDA come from pins (open drain resolved outside) and a free 100 MHz clock.
`timescale 1ns/1ps
module port_select_and_swing_regs
    import redriver_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    // Serial port pins
    input  wire logic                      scl_in,
    input  wire logic                      sda_in,
    output logic                           sda_out,
    output logic                           sda_oe,
    // Port select pin and result per bank
    input  wire logic                      sel_pin,
    output logic [NUM_BANKS-1:0]           port_b_selected,
    // Channel settings
    output logic [NUM_CHANNELS-1:0]        dc_gain_high,
    output logic [NUM_CHANNELS*SWING_W-1:0] output_swing_level
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic sel_s1_q, sel_s2_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
        end else begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
            sel_s1_q <= sel_pin;
            sel_s2_q <= sel_s1_q;
        end
    end

    logic scl_rise, scl_fall, start_cond, stop_cond;

    assign scl_rise   = scl_s2_q & ~scl_s3_q;
    assign scl_fall   = ~scl_s2_q & scl_s3_q;
    assign start_cond = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop_cond  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial engine

    reg_write_if bus ();
    link_state_t state_q;
    logic [7:0]  shift_q;
    logic [7:0]  tx_q;
    logic [7:0]  ptr_q;
    logic [2:0]  cnt_q;
    logic        full_q;
    logic        rw_q;
    logic        bank_q;
    logic        mack_q;
    logic        wr_en_q;
    logic [7:0]  wdata_q;
    logic        addr_hit;
    logic        addr_bank;
    assign addr_hit  = (shift_q[7:1] == BANK0_SLAVE_ADDR) || (shift_q[7:1] == BANK1_SLAVE_ADDR);
    assign addr_bank = (shift_q[7:1] == BANK1_SLAVE_ADDR);

    // Bit counter and receive shifter, sampled on SCL rising
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            shift_q <= 8'h00;
            cnt_q   <= 3'h0;
            full_q  <= 1'b0;
            mack_q  <= 1'b1;
        end else if (start_cond) begin
            cnt_q  <= 3'h0;
            full_q <= 1'b0;
        end else if (scl_rise) begin
            unique case (state_q)
                S_ADDR, S_REG, S_WDATA, S_RD: begin
                    shift_q <= {shift_q[6:0], sda_s2_q};
                    cnt_q   <= cnt_q + 3'h1;
                    full_q  <= (cnt_q == 3'h7);
                end
                S_RDACK: begin
                    mack_q <= sda_s2_q;
                end
                default: begin
                    full_q <= 1'b0;
                end
            endcase
        end else if (scl_fall && full_q) begin
            full_q <= 1'b0;
        end
    end

    // Protocol state, acknowledge and transmit drive, changed on SCL falling
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= S_IDLE;
            sda_oe  <= 1'b0;
            tx_q    <= 8'h00;
            rw_q    <= 1'b0;
            bank_q  <= 1'b0;
            ptr_q   <= 8'h00;
            wr_en_q <= 1'b0;
            wdata_q <= 8'h00;
            sda_out <= 1'b0;
        end else begin
            wr_en_q <= 1'b0;
            sda_out <= 1'b0;
            if (stop_cond) begin
                state_q <= S_IDLE;
                sda_oe  <= 1'b0;
            end else if (start_cond) begin
                state_q <= S_ADDR;
                sda_oe  <= 1'b0;
            end else if (scl_fall) begin
                unique case (state_q)
                    S_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    S_ADDR: begin
                        if (full_q && addr_hit) begin
                            state_q <= S_AACK;
                            sda_oe  <= 1'b1;
                            rw_q    <= shift_q[0];
                            bank_q  <= addr_bank;
                        end else if (full_q) begin
                            state_q <= S_IDLE;
                        end
                    end
                    S_AACK: begin
                        if (rw_q) begin
                            state_q <= S_RD;
                            tx_q    <= bus.rdata;
                            sda_oe  <= ~bus.rdata[7];
                        end else begin
                            state_q <= S_REG;
                            sda_oe  <= 1'b0;
                        end
                    end
                    S_REG: begin
                        if (full_q) begin
                            state_q <= S_RACK;
                            ptr_q   <= shift_q;
                            sda_oe  <= 1'b1;
                        end
                    end
                    S_RACK: begin
                        state_q <= S_WDATA;
                        sda_oe  <= 1'b0;
                    end
                    S_WDATA: begin
                        if (full_q) begin
                            state_q <= S_WACK;
                            wr_en_q <= 1'b1;
                            wdata_q <= shift_q;
                            sda_oe  <= 1'b1;
                        end
                    end
                    S_WACK: begin
                        state_q <= S_WDATA;
                        ptr_q   <= ptr_q + 8'h01;
                        sda_oe  <= 1'b0;
                    end
                    S_RD: begin
                        if (full_q) begin
                            state_q <= S_RDACK;
                            sda_oe  <= 1'b0;
                        end else begin
                            tx_q   <= {tx_q[6:0], 1'b0};
                            sda_oe <= ~tx_q[6];
                        end
                    end
                    S_RDACK: begin
                        if (!mack_q) begin
                            state_q <= S_RD;
                            ptr_q   <= ptr_q + 8'h01;
                            tx_q    <= bus.rdata;
                            sda_oe  <= ~bus.rdata[7];
                        end else begin
                            state_q <= S_IDLE;
                            sda_oe  <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // Read pointer moves on the host acknowledge so the next byte is ready at the fall
    logic [7:0] rd_ptr;
    assign rd_ptr = (state_q == S_RDACK && !mack_q) ? ptr_q + 8'h01 : ptr_q;
    assign bus.wr_en = wr_en_q;
    assign bus.bank  = bank_q;
    assign bus.addr  = (state_q == S_WACK) ? ptr_q : rd_ptr;
    assign bus.wdata = wdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Port select registers, one pair per bank

    logic [NUM_BANKS-1:0] ovr_q;
    logic [NUM_BANKS-1:0] selval_q;
    logic [NUM_BANKS-1:0] sel_eff;
    generate
        for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    ovr_q[b] <= OVR_RESET;
                end else if (wr_en_q && bank_q == 1'(b) && ptr_q == OFF_SEL_OVERRIDE) begin
                    ovr_q[b] <= wdata_q[SEL_BIT];
                end
            end

            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    selval_q[b] <= SEL_RESET;
                end else if (wr_en_q && bank_q == 1'(b) && ptr_q == OFF_SEL_VALUE) begin
                    selval_q[b] <= wdata_q[SEL_BIT];
                end
            end

            assign sel_eff[b] = ovr_q[b] ? selval_q[b] : sel_s2_q;

            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    port_b_selected[b] <= SEL_RESET;
                end else begin
                    port_b_selected[b] <= sel_eff[b];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Channel gain and swing settings
    generate
        for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
            chan_setting #(
                .BANK_IDX (1'(c / CH_PER_BANK)),
                .CH_IDX   (1'(c % CH_PER_BANK))
            ) u_chan (
                .ref_clk (ref_clk),
                .reset   (reset),
                .bus     (bus),
                .gain_q  (dc_gain_high[c]),
                .swing_q (output_swing_level[c*SWING_W +: SWING_W])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Read-back; reserved bits and unmapped offsets read zero

    logic [1:0] ch_base;
    logic [7:0] gs0, gs1;
    assign ch_base = {bank_q, 1'b0};
    assign gs0 = 8'({dc_gain_high[ch_base], output_swing_level[ch_base*SWING_W +: SWING_W]});
    assign gs1 = 8'({dc_gain_high[ch_base+2'h1], output_swing_level[(ch_base+2'h1)*SWING_W +: SWING_W]});
    always_comb begin
        bus.rdata = 8'h00;
        unique case (bus.addr)
            OFF_SEL_OVERRIDE: bus.rdata = 8'(ovr_q[bank_q]) << SEL_BIT;
            OFF_SEL_VALUE:    bus.rdata = 8'(selval_q[bank_q]) << SEL_BIT;
            OFF_BCAST_GS:     bus.rdata = gs0;
            OFF_CH0_GS:       bus.rdata = gs0;
            OFF_CH1_GS:       bus.rdata = gs1;
            default:          bus.rdata = 8'h00;
        endcase
    end

endmodule

// ===== port_select_and_swing_regs_checker.sv
// Concurrent checks on the pins of the redriver register bank.
// Assumes a bind onto port_select_and_swing_regs; one clock domain.
`timescale 1ns/1ps
module psr_checker (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    // Serial port and select pin
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       sel_pin,
    // Settings
    input wire logic [1:0] port_b_selected,
    input wire logic [3:0] dc_gain_high,
    input wire logic [7:0] output_swing_level
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic       sel_prev_q;
    logic [3:0] sel_age_q;

    // Cycles since the select pin last moved
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sel_prev_q <= 1'b0;
            sel_age_q <= 4'h0;
        end else begin
            sel_prev_q <= sel_pin;
            if (sel_pin != sel_prev_q) begin
                sel_age_q <= 4'h0;
            end else if (sel_age_q != 4'hF) begin
                sel_age_q <= sel_age_q + 4'h1;
            end
        end
    end

    ////////////////////////////////////////
    reset_values_a: assert property (
        $fell(reset) |-> dc_gain_high == 4'h0 && output_swing_level == 8'hFF && port_b_selected == 2'h0
    ) else $error("settings not at defaults after reset");
    drive_low_only_a: assert property (sda_oe |-> sda_out == 1'b0) else $error("data pin driven high");
    oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_in) else $error("data drive began in clock high");
    oe_fall_low_a: assert property ($fell(sda_oe) |-> !scl_in) else $error("data drive ended in clock high");
    oe_steady_high_a: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe)
    ) else $error("data drive moved while clock high");
    ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("data drive too short");
    ack_release_a: assert property ($rose(sda_oe) |-> ##[8:300] !sda_oe) else $error("data drive never released");
    swing_on_write_a: assert property (
        $changed(output_swing_level) |-> ##[0:4] sda_oe
    ) else $error("swing moved without a register write");
    gain_on_write_a: assert property (
        $changed(dc_gain_high) |-> ##[0:4] sda_oe
    ) else $error("gain moved without a register write");
    port_cause_a: assert property (
        $changed(port_b_selected) |-> sda_oe || sel_age_q < 4'h8
    ) else $error("port choice moved without pin or write");
endmodule

bind port_select_and_swing_regs psr_checker chk_u (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .sel_pin(sel_pin), .port_b_selected(port_b_selected),
    .dc_gain_high(dc_gain_high), .output_swing_level(output_swing_level)
);

// ===== i2c_host_model.sv
// Two-wire bus host issuing register writes and reads.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ps
module i2c_host_model (
    // Clock
    input wire logic ref_clk,
    // Bus lines
    output logic     scl,
    output logic     sda_low,
    input wire logic sda_wire
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Data moves mid low phase, clear of both clock edges
    task automatic bit_io(input logic b, output logic r);
        gap(4);
        sda_low = ~b;
        gap(4);
        scl = 1'b1;
        gap(8);
        r = sda_wire;
        scl = 1'b0;
    endtask
    task automatic start();
        gap(4);
        sda_low = 1'b0;
        gap(4);
        scl = 1'b1;
        gap(8);
        sda_low = 1'b1;
        gap(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        gap(4);
        sda_low = 1'b1;
        gap(4);
        scl = 1'b1;
        gap(8);
        sda_low = 1'b0;
        gap(8);
    endtask
    task automatic put(input logic [7:0] d, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, nack);
    endtask
    // Last byte of a read: the host answers with no acknowledge
    task automatic get(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] dat, output logic nack);
        logic n0;
        logic n1;
        logic n2;
        start();
        put({dev, 1'b0}, n0);
        put(off, n1);
        put(dat, n2);
        stop();
        nack = n0 | n1 | n2;
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] off, output logic [7:0] dat);
        logic n;
        start();
        put({dev, 1'b0}, n);
        put(off, n);
        start();
        put({dev, 1'b1}, n);
        get(dat);
        stop();
    endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the redriver register bank.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
module testbench;
    import redriver_cfg_pkg::*;
    logic       ref_clk, reset, sel_pin, scl, host_low, sda_out, sda_oe, sda_wire;
    logic [1:0] port_b_selected;
    logic [3:0] dc_gain_high;
    logic [7:0] output_swing_level;
    logic [7:0] rd_q;
    int         error_cnt;
    int         n_tests;

    assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~host_low;
    port_select_and_swing_regs dut_u (
        .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .sel_pin(sel_pin), .port_b_selected(port_b_selected),
        .dc_gain_high(dc_gain_high), .output_swing_level(output_swing_level)
    );
    i2c_host_model host_u (.ref_clk(ref_clk), .scl(scl), .sda_low(host_low), .sda_wire(sda_wire));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int b, input logic [7:0] off, input logic [7:0] dat);
        logic nack;
        host_u.wr(b ? BANK1_SLAVE_ADDR : BANK0_SLAVE_ADDR, off, dat, nack);
        check({7'h00, nack}, 8'h00);
    endtask
    task automatic rd(input int b, input logic [7:0] off);
        host_u.rd(b ? BANK1_SLAVE_ADDR : BANK0_SLAVE_ADDR, off, rd_q);
    endtask
    task automatic rmw(input int b, input logic [7:0] off, input logic [7:0] mask, input logic [7:0] val);
        rd(b, off);
        wr(b, off, (rd_q & ~mask) | (val & mask));
    endtask

    ////////////////////////////////////////
    task automatic t_defaults();
        check(8'(dc_gain_high), 8'h00);
        check(output_swing_level, 8'hFF);
        for (int b = 0; b < 2; b++) begin
            rd(b, OFF_SEL_OVERRIDE);
            check(rd_q, 8'h00);
            rd(b, OFF_SEL_VALUE);
            check(rd_q, 8'h00);
            rd(b, OFF_BCAST_GS);
            check(rd_q, 8'h03);
        end
    endtask
    task automatic t_pin();
        sel_pin = 1'b1;
        host_u.gap(6);
        check(8'(port_b_selected), 8'h03);
        sel_pin = 1'b0;
        host_u.gap(6);
        check(8'(port_b_selected), 8'h00);
    endtask
    task automatic t_override();
        rmw(0, OFF_SEL_OVERRIDE, 8'h04, 8'h04);
        rmw(0, OFF_SEL_VALUE, 8'h04, 8'h04);
        check(8'(port_b_selected), 8'h01);
        sel_pin = 1'b1;
        rmw(0, OFF_SEL_VALUE, 8'h04, 8'h00);
        check(8'(port_b_selected), 8'h02);
        wr(0, OFF_SEL_OVERRIDE, 8'h00);
        check(8'(port_b_selected), 8'h03);
        sel_pin = 1'b0;
        wr(1, OFF_SEL_VALUE, 8'hFF);
        rd(1, OFF_SEL_VALUE);
        check(rd_q, 8'h04);
        wr(1, OFF_SEL_VALUE, 8'h00);
    endtask
    task automatic t_gain();
        rmw(1, OFF_BCAST_GS, 8'h04, 8'h04);
        check(8'(dc_gain_high), 8'h0C);
        check(output_swing_level, 8'hFF);
        rmw(0, OFF_BCAST_GS, 8'h04, 8'h04);
        check(8'(dc_gain_high), 8'h0F);
        wr(0, OFF_BCAST_GS, 8'h03);
        wr(1, OFF_BCAST_GS, 8'h03);
        check(8'(dc_gain_high), 8'h00);
    endtask
    task automatic t_swing();
        logic [3:0] f;
        for (int b = 0; b < 2; b++) begin
            for (int c = 0; c < 4; c++) begin
                f = {c[1:0], c[1:0]};
                rmw(b, OFF_BCAST_GS, 8'h03, 8'(c));
                check(output_swing_level, b ? {f, 4'hF} : {4'hF, f});
                check(8'(dc_gain_high), 8'h00);
            end
        end
    endtask
    task automatic t_chan();
        wr(0, OFF_CH0_GS, 8'h06);
        check(8'(dc_gain_high), 8'h01);
        check(output_swing_level, 8'hFE);
        rd(0, OFF_CH0_GS);
        check(rd_q, 8'h06);
        wr(0, OFF_CH0_GS, 8'h03);
        check(output_swing_level, 8'hFF);
        wr(1, OFF_CH1_GS, 8'h05);
        check(8'(dc_gain_high), 8'h08);
        check(output_swing_level, 8'h7F);
        rd(1, OFF_CH1_GS);
        check(rd_q, 8'h05);
        wr(1, OFF_CH1_GS, 8'h03);
        check(output_swing_level, 8'hFF);
    endtask
    task automatic t_refused();
        logic nack;
        host_u.wr(7'h1A, OFF_BCAST_GS, 8'h00, nack);
        check({7'h00, nack}, 8'h01);
        check(output_swing_level, 8'hFF);
        wr(0, 8'h40, 8'hAA);
        rd(0, 8'h40);
        check(rd_q, 8'h00);
        check(8'(dc_gain_high), 8'h00);
    endtask

    ////////////////////////////////////////
    task automatic results();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        sel_pin = 1'b0;
        error_cnt = 0;
        n_tests = 0;
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        host_u.gap(2);
        t_defaults();
        t_pin();
        t_override();
        t_gain();
        t_swing();
        t_chan();
        t_refused();
        results();
    end
    // Roughly four times the expected run
    initial begin
        #1_000_000;
        error_cnt++;
        results();
    end
endmodule
